//--- rtl/pfs_deadline_timer.sv
// Deadline supervisor: flags when a goal is not met in time after a start.
// Assumes i_limit is at least one and stays steady while running.
`timescale 1ns/1ps
module pfs_deadline_timer #(
  parameter int W = 32
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_start,
  input  wire logic         i_arm,
  input  wire logic         i_done,
  input  wire logic [W-1:0] i_limit,
  output logic              o_expired
);
  import pfs_pkg::*;

  logic         running;
  logic [W-1:0] count;
  logic         last_cycle;

  assign last_cycle = running && i_arm && !i_done && !i_start
                      && (count == i_limit - W'(1));

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      running <= 1'b0;
      count   <= '0;
    end else if (i_start && i_arm) begin
      running <= 1'b1;
      count   <= '0;
    end else if (running) begin
      if (!i_arm || i_done || last_cycle) begin
        running <= 1'b0;
      end else begin
        count <= count + W'(1);
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_expired <= 1'b0;
    end else begin
      o_expired <= last_cycle;
    end
  end

endmodule

//--- rtl/pfs_pkg.sv
// Package for the power and fault status register pair.
// Assumes a single 40 MHz core clock; all figures are held here once.
package pfs_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] PFS_ADDR_POWER_STATUS = 8'h1E;
  localparam logic [7:0] PFS_ADDR_FAULT_STATUS = 8'h1F;
  localparam logic [7:0] PFS_POWER_STATUS_RST  = 8'h08;
  localparam logic [7:0] PFS_FAULT_STATUS_RST  = 8'h80;
  localparam logic [7:0] PFS_FAULT_IMPL_MASK   = 8'hB3;
  localparam logic [7:0] PFS_FAULT_SWRST_MASK  = 8'h33;

  // --------------------------------------------------------------------------
  // Power status bit positions
  // --------------------------------------------------------------------------
  localparam int PFS_PS_DEBUG_ACCESSORY_ATTACHED   = 7;
  localparam int PFS_PS_INIT_PEND   = 6;
  localparam int PFS_PS_SRC_HIGH    = 5;
  localparam int PFS_PS_SRC_BUS     = 4;
  localparam int PFS_PS_DETECT_ON   = 3;
  localparam int PFS_PS_BUS_PRESENT = 2;
  localparam int PFS_PS_CABLE_PRES  = 1;
  localparam int PFS_PS_SINKING     = 0;

  // --------------------------------------------------------------------------
  // Fault status bit positions
  // --------------------------------------------------------------------------
  localparam int PFS_FS_REGS_DEFAULT = 7;
  localparam int PFS_FS_AUTO_DISCHARGE_ENABLE   = 5;
  localparam int PFS_FS_FORCED_DISCHARGE_ENABLE  = 4;
  localparam int PFS_FS_CABLE_OCP    = 1;
  localparam int PFS_FS_CMD_ERROR    = 0;

  // --------------------------------------------------------------------------
  // Power commands and minimum transmit byte count
  // --------------------------------------------------------------------------
  localparam logic [7:0] PFS_CMD_BUS_DETECT_OFF = 8'h22;
  localparam logic [7:0] PFS_CMD_START_SINKING  = 8'h55;
  localparam logic [7:0] PFS_CMD_SOURCE_DEFAULT = 8'h77;
  localparam logic [7:0] PFS_CMD_SOURCE_HIGH    = 8'h88;
  localparam logic [7:0] PFS_MIN_TX_BYTES       = 8'h02;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int PFS_CLK_KHZ        = 40_000;
  localparam int PFS_T_SAFE5V_MS    = 275;
  localparam int PFS_T_SAFE0V_MS    = 650;
  localparam int PFS_T_SRC_SETTLE_MS = 275;
  localparam int PFS_SAFE5V_CYC     = PFS_T_SAFE5V_MS * PFS_CLK_KHZ;
  localparam int PFS_SAFE0V_CYC     = PFS_T_SAFE0V_MS * PFS_CLK_KHZ;
  localparam int PFS_SRC_SETTLE_CYC = PFS_T_SRC_SETTLE_MS * PFS_CLK_KHZ;

endpackage

//--- rtl/pfs_power_fault_regs.sv
// Power status and fault status registers of a port controller.
// Assumes register accesses and all status inputs are in the core clock domain.
`timescale 1ns/1ps
module pfs_power_fault_regs #(
  parameter int unsigned SAFE5V_CYC     = pfs_pkg::PFS_SAFE5V_CYC,
  parameter int unsigned SAFE0V_CYC     = pfs_pkg::PFS_SAFE0V_CYC,
  parameter int unsigned SRC_SETTLE_CYC = pfs_pkg::PFS_SRC_SETTLE_CYC
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset_n,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  input  wire logic       i_debug_accessory_attached,
  input  wire logic       i_controller_init_pending,
  input  wire logic       i_sourcing_high_voltage,
  input  wire logic       i_source_switch_output,
  input  wire logic       i_sourcing_enabled,
  input  wire logic       i_bus_present_detect_on,
  input  wire logic       i_bus_power_present,
  input  wire logic       i_cable_supply_detected,
  input  wire logic       i_cable_supply_enable,
  input  wire logic       i_sink_switch_output,
  input  wire logic       i_software_reset,
  input  wire logic       i_auto_discharge_enable,
  input  wire logic       i_disconnect_detected,
  input  wire logic       i_bus_below_safe5v,
  input  wire logic       i_bus_below_safe0v,
  input  wire logic       i_forced_discharge_enable,
  input  wire logic       i_stop_level_at_safe0v,
  input  wire logic       i_bus_below_stop_level,
  input  wire logic       i_cable_supply_overcurrent,
  input  wire logic       i_cmd_valid,
  input  wire logic [7:0] i_cmd_code,
  input  wire logic       i_can_source_high,
  input  wire logic       i_sink_transmit_req,
  input  wire logic [7:0] i_transmit_byte_count,
  input  wire logic       i_connect_invalid,
  output logic            o_cmd_accept,
  output logic            o_power_change_event,
  output logic            o_forced_discharge_end
);
  import pfs_pkg::*;

  logic [7:0] power_status;
  logic [7:0] next_power_status;
  logic [7:0] fault_status;
  logic [7:0] fault_set;
  logic [7:0] fault_clear;
  logic       sourcing;
  logic       sinking;
  logic       cmd_conflict;
  logic       tx_short;
  logic       forced_prev;
  logic       forced_start;
  logic       safe5_late;
  logic       safe0_late;
  logic       forced_late;
  logic [31:0] forced_limit;

  // --------------------------------------------------------------------------
  // Power status capture
  // --------------------------------------------------------------------------
  assign sourcing = i_source_switch_output && i_sourcing_enabled;
  assign sinking  = i_sink_switch_output;

  always_comb begin
    next_power_status                     = 8'h00;
    next_power_status[PFS_PS_DEBUG_ACCESSORY_ATTACHED]   = i_debug_accessory_attached;
    next_power_status[PFS_PS_INIT_PEND]   = i_controller_init_pending;
    next_power_status[PFS_PS_SRC_HIGH]    = i_sourcing_high_voltage;
    next_power_status[PFS_PS_SRC_BUS]     = sourcing;
    next_power_status[PFS_PS_DETECT_ON]   = i_bus_present_detect_on;
    next_power_status[PFS_PS_BUS_PRESENT] = i_bus_power_present;
    next_power_status[PFS_PS_CABLE_PRES]  = i_cable_supply_detected
                                            && i_cable_supply_enable;
    next_power_status[PFS_PS_SINKING]     = sinking;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      power_status <= PFS_POWER_STATUS_RST;
    end else begin
      power_status <= next_power_status;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_power_change_event <= 1'b0;
    end else begin
      o_power_change_event <= (next_power_status != power_status);
    end
  end

  // --------------------------------------------------------------------------
  // Command screening
  // --------------------------------------------------------------------------
  always_comb begin
    cmd_conflict = 1'b0;
    case (i_cmd_code)
      PFS_CMD_BUS_DETECT_OFF: cmd_conflict = sinking || sourcing;
      PFS_CMD_START_SINKING:  cmd_conflict = sourcing;
      PFS_CMD_SOURCE_DEFAULT: cmd_conflict = sinking;
      PFS_CMD_SOURCE_HIGH:    cmd_conflict = !(sourcing && !i_sourcing_high_voltage)
                                             || sinking || !i_can_source_high;
      default:                cmd_conflict = 1'b0;
    endcase
  end

  assign o_cmd_accept = i_cmd_valid && !cmd_conflict;
  assign tx_short     = i_sink_transmit_req && (i_transmit_byte_count < PFS_MIN_TX_BYTES);

  // --------------------------------------------------------------------------
  // Discharge supervision
  // --------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      forced_prev <= 1'b0;
    end else begin
      forced_prev <= i_forced_discharge_enable;
    end
  end

  assign forced_start = i_forced_discharge_enable && !forced_prev;
  assign forced_limit = i_stop_level_at_safe0v ? 32'(SAFE0V_CYC) : 32'(SRC_SETTLE_CYC);
  assign o_forced_discharge_end = i_forced_discharge_enable && i_bus_below_safe0v;

  pfs_deadline_timer #(.W(32)) u_auto_safe5 (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_start   (i_disconnect_detected),
    .i_arm     (i_auto_discharge_enable),
    .i_done    (i_bus_below_safe5v),
    .i_limit   (32'(SAFE5V_CYC)),
    .o_expired (safe5_late)
  );

  pfs_deadline_timer #(.W(32)) u_auto_safe0 (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_start   (i_disconnect_detected),
    .i_arm     (i_auto_discharge_enable),
    .i_done    (i_bus_below_safe0v),
    .i_limit   (32'(SAFE0V_CYC)),
    .o_expired (safe0_late)
  );

  pfs_deadline_timer #(.W(32)) u_forced (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_start   (forced_start),
    .i_arm     (i_forced_discharge_enable),
    .i_done    (i_stop_level_at_safe0v ? i_bus_below_safe0v : i_bus_below_stop_level),
    .i_limit   (forced_limit),
    .o_expired (forced_late)
  );

  // --------------------------------------------------------------------------
  // Fault status
  // --------------------------------------------------------------------------
  always_comb begin
    fault_set                      = 8'h00;
    fault_set[PFS_FS_AUTO_DISCHARGE_ENABLE]   = safe5_late || safe0_late;
    fault_set[PFS_FS_FORCED_DISCHARGE_ENABLE]  = forced_late;
    fault_set[PFS_FS_CABLE_OCP]    = i_cable_supply_overcurrent;
    fault_set[PFS_FS_CMD_ERROR]    = tx_short
                                     || (i_cmd_valid && cmd_conflict)
                                     || i_connect_invalid;
  end

  // Bit 7 has no set source: only power-on defaults raise it
  always_comb begin
    fault_clear = 8'h00;
    if (i_reg_wr && (i_reg_addr == PFS_ADDR_FAULT_STATUS)) begin
      fault_clear = i_reg_wdata & PFS_FAULT_IMPL_MASK;
    end
    if (i_software_reset) begin
      fault_clear = fault_clear | PFS_FAULT_SWRST_MASK;
    end
  end

  for (genvar b = 0; b < 8; b++) begin : g_fault
    if (PFS_FAULT_IMPL_MASK[b]) begin : g_impl
      pfs_sticky_bit #(.RST_VAL(PFS_FAULT_STATUS_RST[b])) u_bit (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_set     (fault_set[b]),
        .i_clear   (fault_clear[b]),
        .o_flag    (fault_status[b])
      );
    end else begin : g_rsvd
      assign fault_status[b] = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        PFS_ADDR_POWER_STATUS: o_reg_rdata <= power_status;
        PFS_ADDR_FAULT_STATUS: o_reg_rdata <= fault_status;
        default:               o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  a_read_power: assert property (
    i_reg_rd && i_reg_addr == PFS_ADDR_POWER_STATUS |=> o_reg_rdata == $past(power_status))
    else $error("power status read data wrong");
  a_change_event: assert property (
    o_power_change_event == (power_status != $past(power_status)))
    else $error("power change event mismatch");
  a_debug_mirror: assert property (
    i_debug_accessory_attached |=> power_status[PFS_PS_DEBUG_ACCESSORY_ATTACHED])
    else $error("debug accessory bit not mirrored");
  a_source_bit: assert property (
    ##1 power_status[PFS_PS_SRC_BUS] == $past(i_source_switch_output && i_sourcing_enabled))
    else $error("sourcing bit wrong");
  a_cable_bit: assert property (
    !i_cable_supply_enable |=> !power_status[PFS_PS_CABLE_PRES])
    else $error("cable supply bit set while disabled");
  a_fault_hold: assert property (
    fault_status[PFS_FS_CABLE_OCP] && !fault_clear[PFS_FS_CABLE_OCP]
    |=> fault_status[PFS_FS_CABLE_OCP])
    else $error("fault bit lost without clear");
  a_fault_clear: assert property (
    fault_clear[PFS_FS_CMD_ERROR] && !fault_set[PFS_FS_CMD_ERROR]
    |=> !fault_status[PFS_FS_CMD_ERROR])
    else $error("fault bit not cleared");
  a_ocp_latch: assert property (
    i_cable_supply_overcurrent |=> fault_status[PFS_FS_CABLE_OCP]
    ##1 (fault_status[PFS_FS_CABLE_OCP] || $past(fault_clear[PFS_FS_CABLE_OCP])))
    else $error("overcurrent not latched");
  a_tx_short: assert property (
    i_sink_transmit_req && i_transmit_byte_count < PFS_MIN_TX_BYTES
    |=> fault_status[PFS_FS_CMD_ERROR])
    else $error("short transmit not flagged");
  a_cmd_reject: assert property (
    i_cmd_valid && i_cmd_code == PFS_CMD_START_SINKING && sourcing
    |-> !o_cmd_accept ##1 fault_status[PFS_FS_CMD_ERROR])
    else $error("conflicting sink command accepted");
  a_discharge_fail: assert property (
    forced_late |=> fault_status[PFS_FS_FORCED_DISCHARGE_ENABLE])
    else $error("forced discharge failure not latched");
  a_forced_end: assert property (
    i_forced_discharge_enable && i_bus_below_safe0v |-> o_forced_discharge_end)
    else $error("forced discharge not ended");
  a_reserved_zero: assert property (
    (fault_status & ~PFS_FAULT_IMPL_MASK) == 8'h00)
    else $error("reserved fault bit set");
  a_init_bit: assert property (
    ##1 power_status[PFS_PS_INIT_PEND] == $past(i_controller_init_pending))
    else $error("init pending bit wrong");
  a_swrst_keep: assert property (
    i_software_reset && !fault_status[PFS_FS_REGS_DEFAULT]
    |=> !fault_status[PFS_FS_REGS_DEFAULT])
    else $error("software reset set the defaults flag");
  a_auto_fail: assert property (
    safe5_late || safe0_late |=> fault_status[PFS_FS_AUTO_DISCHARGE_ENABLE])
    else $error("auto discharge failure not latched");
  a_invalid_conn: assert property (
    i_connect_invalid |=> fault_status[PFS_FS_CMD_ERROR])
    else $error("invalid connection not flagged");

  c_change:   cover property (o_power_change_event);
  c_reject:   cover property (i_cmd_valid && !o_cmd_accept);
  c_auto:     cover property (safe5_late || safe0_late);
  c_clear_ocp: cover property (fault_status[PFS_FS_CABLE_OCP] ##1 !fault_status[PFS_FS_CABLE_OCP]);

endmodule

//--- rtl/pfs_sticky_bit.sv
// One latched status flag with hardware set and write-one clear.
// Assumes set and clear are single-cycle requests in the core clock domain.
`timescale 1ns/1ps
module pfs_sticky_bit #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);
  import pfs_pkg::*;

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_flag <= RST_VAL;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clear) begin
      o_flag <= 1'b0;
    end
  end

endmodule

//--- sim/pfs_host_model.sv
// Host model for the power and fault status pair: one-cycle register strobes.
// Assumes callers share the core clock; strobes change at the falling edge.
`timescale 1ns/1ps
module pfs_host_model (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_reg_rdata,
  output logic      [7:0] o_reg_addr,
  output logic            o_reg_wr,
  output logic      [7:0] o_reg_wdata,
  output logic            o_reg_rd
);
  // --------------------------------------------------------------------------
  // Idle bus shows inverted last value
  // --------------------------------------------------------------------------
  initial begin
    o_reg_addr  = 8'hFF;
    o_reg_wr    = 1'b0;
    o_reg_wdata = 8'hFF;
    o_reg_rd    = 1'b0;
  end

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_ref_clk);
    o_reg_addr  = addr;
    o_reg_wdata = data;
    o_reg_wr    = 1'b1;
    @(negedge i_ref_clk);
    o_reg_wr    = 1'b0;
    o_reg_addr  = ~addr;
    o_reg_wdata = ~data;
  endtask

  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge i_ref_clk);
    o_reg_addr = addr;
    o_reg_rd   = 1'b1;
    @(negedge i_ref_clk);
    o_reg_rd   = 1'b0;
    o_reg_addr = ~addr;
    @(negedge i_ref_clk);
    data = i_reg_rdata;
  endtask
endmodule

//--- sim/power_fault_status_regs_tb.sv
// Testbench for the power and fault status register pair.
// Assumes short discharge deadlines of 20, 30 and 25 cycles.
`timescale 1ns/1ps
module power_fault_status_regs_tb;
  import pfs_pkg::*;
  logic       ref_clk, reset_n, reg_wr, reg_rd, src_en, vc_en, auto_en, below5, below0;
  logic       force_en, stop0, below_stop, cmd_valid, can_hv, cmd_accept, pwr_event, force_end;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ps_drv, cmd_code, tx_cnt;
  logic [4:0] pls;
  int         err_count, total_checks, ev_count;
  // Entries: power inputs, command, can source high, expected accept
  localparam logic [23:0] CASES [12] = '{24'h01_22_10, 24'h01_77_10, 24'h01_88_10,
    24'h10_55_10, 24'h10_22_10, 24'h10_88_11, 24'h10_88_00, 24'h30_88_10,
    24'h00_55_11, 24'h00_77_11, 24'h00_22_11, 24'h00_88_10};

  pfs_power_fault_regs #(.SAFE5V_CYC(20), .SAFE0V_CYC(30), .SRC_SETTLE_CYC(25))
    u_pfs_power_fault_regs (
    .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_reg_addr(reg_addr),
    .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .i_debug_accessory_attached(ps_drv[7]),
    .i_controller_init_pending(ps_drv[6]), .i_sourcing_high_voltage(ps_drv[5]),
    .i_source_switch_output(ps_drv[4]), .i_sourcing_enabled(src_en),
    .i_bus_present_detect_on(ps_drv[3]), .i_bus_power_present(ps_drv[2]),
    .i_cable_supply_detected(ps_drv[1]), .i_cable_supply_enable(vc_en),
    .i_sink_switch_output(ps_drv[0]), .i_software_reset(pls[1]),
    .i_auto_discharge_enable(auto_en), .i_disconnect_detected(pls[2]),
    .i_bus_below_safe5v(below5), .i_bus_below_safe0v(below0),
    .i_forced_discharge_enable(force_en), .i_stop_level_at_safe0v(stop0),
    .i_bus_below_stop_level(below_stop), .i_cable_supply_overcurrent(pls[0]),
    .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code), .i_can_source_high(can_hv),
    .i_sink_transmit_req(pls[4]), .i_transmit_byte_count(tx_cnt),
    .i_connect_invalid(pls[3]), .o_cmd_accept(cmd_accept),
    .o_power_change_event(pwr_event), .o_forced_discharge_end(force_end));

  pfs_host_model u_pfs_host_model (
    .i_ref_clk(ref_clk), .i_reg_rdata(reg_rdata), .o_reg_addr(reg_addr),
    .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd));

  // --------------------------------------------------------------------------
  // Clock, event counter, watchdog
  // --------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (pwr_event === 1'b1) ev_count++;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    final_report();
  end

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    u_pfs_host_model.reg_read(addr, d);
    chk(d, exp);
  endtask

  task automatic ps_step(input logic [7:0] v, input logic en, input logic [7:0] nev);
    int e0;
    @(negedge ref_clk);
    e0 = ev_count;
    ps_drv = v;
    src_en = en;
    vc_en = en;
    repeat (4) @(negedge ref_clk);
    chk(8'(ev_count - e0), nev);
  endtask

  task automatic pulse(input int idx);
    @(negedge ref_clk);
    pls[idx] = 1'b1;
    @(negedge ref_clk);
    pls[idx] = 1'b0;
  endtask

  task automatic clr_chk(input logic [7:0] exp);
    rd_chk(PFS_ADDR_FAULT_STATUS, exp);
    u_pfs_host_model.reg_write(PFS_ADDR_FAULT_STATUS, exp);
    rd_chk(PFS_ADDR_FAULT_STATUS, 8'h00);
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    {reset_n, auto_en, below5, below0, force_en, stop0, below_stop} = '0;
    {cmd_valid, can_hv, src_en, vc_en} = 4'h3;
    {ps_drv, cmd_code, tx_cnt, pls} = {8'h08, 16'h0000, 5'h00};
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    rd_chk(PFS_ADDR_POWER_STATUS, 8'h08);
    rd_chk(PFS_ADDR_FAULT_STATUS, 8'h80);
    rd_chk(8'h20, 8'h00);
    for (int i = 0; i < 8; i++) begin
      ps_step(8'(1 << i), 1'b1, 8'h01);
      rd_chk(PFS_ADDR_POWER_STATUS, 8'(1 << i));
    end
    ps_step(8'h80, 1'b1, 8'h00);
    ps_step(8'h12, 1'b0, 8'h01);
    rd_chk(PFS_ADDR_POWER_STATUS, 8'h00);
    ps_step(8'h12, 1'b1, 8'h01);
    u_pfs_host_model.reg_write(PFS_ADDR_POWER_STATUS, 8'hED);
    rd_chk(PFS_ADDR_POWER_STATUS, 8'h12);
    u_pfs_host_model.reg_write(PFS_ADDR_FAULT_STATUS, 8'h7F);
    rd_chk(PFS_ADDR_FAULT_STATUS, 8'h80);
    pulse(0);
    rd_chk(PFS_ADDR_FAULT_STATUS, 8'h82);
    pulse(1);
    clr_chk(8'h80);
    pulse(1);
    rd_chk(PFS_ADDR_FAULT_STATUS, 8'h00);
    for (int i = 0; i < 12; i++) begin
      @(negedge ref_clk);
      ps_drv = CASES[i][23:16];
      can_hv = CASES[i][4];
      @(negedge ref_clk);
      cmd_code = CASES[i][15:8];
      cmd_valid = 1'b1;
      #1 chk({7'h00, cmd_accept}, {7'h00, CASES[i][0]});
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      if (CASES[i][0]) rd_chk(PFS_ADDR_FAULT_STATUS, 8'h00);
      else clr_chk(8'h01);
    end
    tx_cnt = 8'h01;
    pulse(4);
    clr_chk(8'h01);
    tx_cnt = PFS_MIN_TX_BYTES;
    pulse(4);
    rd_chk(PFS_ADDR_FAULT_STATUS, 8'h00);
    pulse(3);
    clr_chk(8'h01);
    auto_en = 1'b1;
    pulse(2);
    repeat (10) @(negedge ref_clk);
    below5 = 1'b1;
    repeat (30) @(negedge ref_clk);
    clr_chk(8'h20);
    below5 = 1'b0;
    pulse(2);
    repeat (22) @(negedge ref_clk);
    {below5, below0} = 2'b11;
    repeat (20) @(negedge ref_clk);
    clr_chk(8'h20);
    pulse(2);
    repeat (40) @(negedge ref_clk);
    rd_chk(PFS_ADDR_FAULT_STATUS, 8'h00);
    {auto_en, below5, below0, stop0, force_en} = 5'b00011;
    repeat (40) @(negedge ref_clk);
    chk({7'h00, force_end}, 8'h00);
    below0 = 1'b1;
    #1 chk({7'h00, force_end}, 8'h01);
    @(negedge ref_clk);
    {force_en, below0, stop0} = 3'b000;
    clr_chk(8'h10);
    force_en = 1'b1;
    repeat (20) @(negedge ref_clk);
    rd_chk(PFS_ADDR_FAULT_STATUS, 8'h00);
    repeat (4) @(negedge ref_clk);
    rd_chk(PFS_ADDR_FAULT_STATUS, 8'h10);
    force_en = 1'b0;
    clr_chk(8'h10);
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    rd_chk(PFS_ADDR_FAULT_STATUS, 8'h80);
    final_report();
  end
endmodule
